// ==== core/ckgate_pkg.sv ====
package ckgate_pkg;

  // ----------------------------------------
  // Register addresses
  // ----------------------------------------
  localparam int CKG_ADDR_W = 20;
  localparam logic [19:0] CKG_ADDR_GATE = 20'hF00F0;
  localparam logic [19:0] CKG_ADDR_PIN = 20'hFFFA0;
  localparam logic [19:0] CKG_ADDR_RUN = 20'hFFFA1;
  localparam logic [19:0] CKG_ADDR_MAIN = 20'hFFFA4;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] CKG_RST_GATE = 8'h00;
  localparam logic [7:0] CKG_RST_PIN = 8'h00;
  localparam logic [7:0] CKG_RST_RUN = 8'hC0;
  localparam logic [7:0] CKG_RST_MAIN = 8'h00;

  // ----------------------------------------
  // Writable bit masks
  // ----------------------------------------
  localparam logic [7:0] CKG_WMASK_GATE = 8'hAD;
  localparam logic [7:0] CKG_WMASK_PIN = 8'hC1;
  localparam logic [7:0] CKG_WMASK_RUN = 8'h81;
  localparam logic [7:0] CKG_WMASK_MAIN = 8'hB0;
  // Bit 6 of run control reads as one
  localparam logic [7:0] CKG_FIXED_RUN = 8'h40;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int CKG_EXT_SEL_BIT = 7;
  localparam int CKG_RES_SEL_BIT = 6;
  localparam int CKG_SYS_STOP_BIT = 7;
  localparam int CKG_HIO_STOP_BIT = 0;
  localparam int CKG_MAIN_SRC_BIT = 4;
  localparam int CKG_PERIPH_N = 5;
  // Interval timer, converter, serial one, serial zero, timer unit
  localparam int CKG_GATE_BIT [CKG_PERIPH_N] = '{7, 5, 3, 2, 0};

  typedef enum logic [1:0] {
    CKG_PIN_PORT,
    CKG_PIN_RESONATOR,
    CKG_PIN_EXTCLK
  } ckg_pin_mode_e;

endpackage

// ==== core/ckgate_top.sv ====
// Function
// RULE_01: Pin bits 00 and 10 input port, 01 resonator, 11 external clock.
// RULE_02: Stop bit halts resonator, or rejects external clock in external mode.
// RULE_03: On-chip oscillator runs while its stop bit is zero.
// RULE_04: Main source bit zero picks on-chip clock, one picks high-speed system clock.
// RULE_05: Interval timer gate zero: no clock, writes blocked, held in reset.
// RULE_06: Converter gate zero: no clock, writes blocked, held in reset.
// RULE_07: Serial unit one gate zero: no clock, writes blocked, held in reset.
// RULE_08: Serial unit zero gate zero: no clock, writes blocked, held in reset.
// RULE_09: Timer unit gate zero: no clock, writes blocked, held in reset.
// RULE_10: Reset state: on-chip clock, oscillator stopped, port mode, peripherals gated.
`timescale 1ns/10ps
module ckgate_top import ckgate_pkg::*; #(
  parameter int PERIPH_N = CKG_PERIPH_N
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Register port
  input wire logic [CKG_ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  // Clock pin and oscillator control
  output logic pin_port_mode,
  output logic resonator_run,
  output logic external_clock_accept,
  output logic onchip_oscillator_run,
  output logic main_source_select,
  // Peripheral write attempts, one bit per peripheral
  input wire logic [PERIPH_N-1:0] periph_write_req,
  // Peripheral gating
  output logic [PERIPH_N-1:0] periph_clock_enable,
  output logic [PERIPH_N-1:0] periph_write_allow,
  output logic [PERIPH_N-1:0] periph_reset_hold,
  output logic [PERIPH_N-1:0] periph_write_grant
);

  // ----------------------------------------
  // Parameter check
  // ----------------------------------------
  // The gate bit table is fixed at five entries
  if (PERIPH_N != CKG_PERIPH_N) begin : g_bad_periph_n
    $error("ckgate_top serves exactly five gated peripherals");
  end

  // ----------------------------------------
  // Register selection
  // ----------------------------------------
  typedef enum logic [2:0] {
    CKG_SEL_NONE,
    CKG_SEL_GATE,
    CKG_SEL_PIN,
    CKG_SEL_RUN,
    CKG_SEL_MAIN
  } ckg_reg_sel_e;

  // Exact match only; partial addresses select nothing
  function automatic ckg_reg_sel_e reg_select(input logic [CKG_ADDR_W-1:0] addr);
    case (addr)
      CKG_ADDR_GATE: reg_select = CKG_SEL_GATE;
      CKG_ADDR_PIN: reg_select = CKG_SEL_PIN;
      CKG_ADDR_RUN: reg_select = CKG_SEL_RUN;
      CKG_ADDR_MAIN: reg_select = CKG_SEL_MAIN;
      default: reg_select = CKG_SEL_NONE;
    endcase
  endfunction

  // Bits outside the mask are not stored; fixed bits are forced on
  function automatic logic [7:0] apply_write(
    input logic [7:0] value,
    input logic [7:0] mask,
    input logic [7:0] fixed
  );
    apply_write = (value & mask) | fixed;
  endfunction

  function automatic ckg_pin_mode_e pin_mode(input logic [7:0] pin_value);
    case ({pin_value[CKG_EXT_SEL_BIT], pin_value[CKG_RES_SEL_BIT]})
      2'h1: pin_mode = CKG_PIN_RESONATOR; // RULE_01
      2'h3: pin_mode = CKG_PIN_EXTCLK; // RULE_01
      default: pin_mode = CKG_PIN_PORT; // RULE_01
    endcase
  endfunction

  function automatic logic gate_of(input logic [7:0] gate_value, input int index);
    gate_of = gate_value[CKG_GATE_BIT[index]];
  endfunction

  ckg_reg_sel_e wr_sel;
  ckg_reg_sel_e rd_sel;

  // Strobes are never both high, so one decode per direction is enough
  always_comb begin
    wr_sel = CKG_SEL_NONE;
    rd_sel = CKG_SEL_NONE;
    if (reg_write) begin
      wr_sel = reg_select(reg_addr);
    end
    if (reg_read) begin
      rd_sel = reg_select(reg_addr);
    end
  end

  // ----------------------------------------
  // Peripheral clock gate register
  // ----------------------------------------
  logic [7:0] gate_reg;
  logic [7:0] gate_next;

  always_comb begin
    gate_next = gate_reg;
    if (wr_sel == CKG_SEL_GATE) begin
      gate_next = apply_write(reg_wdata, CKG_WMASK_GATE, 8'h00);
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      gate_reg <= CKG_RST_GATE; // RULE_10
    end else begin
      gate_reg <= gate_next;
    end
  end

  // ----------------------------------------
  // Clock pin mode register
  // ----------------------------------------
  logic [7:0] pin_reg;
  logic [7:0] pin_next;

  always_comb begin
    pin_next = pin_reg;
    if (wr_sel == CKG_SEL_PIN) begin
      pin_next = apply_write(reg_wdata, CKG_WMASK_PIN, 8'h00);
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_reg <= CKG_RST_PIN; // RULE_10
    end else begin
      pin_reg <= pin_next;
    end
  end

  // ----------------------------------------
  // Oscillator run control register
  // ----------------------------------------
  logic [7:0] run_reg;
  logic [7:0] run_next;

  always_comb begin
    run_next = run_reg;
    if (wr_sel == CKG_SEL_RUN) begin
      run_next = apply_write(reg_wdata, CKG_WMASK_RUN, CKG_FIXED_RUN);
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      run_reg <= CKG_RST_RUN; // RULE_10
    end else begin
      run_reg <= run_next;
    end
  end

  // ----------------------------------------
  // Main clock select register
  // ----------------------------------------
  logic [7:0] main_reg;
  logic [7:0] main_next;

  always_comb begin
    main_next = main_reg;
    if (wr_sel == CKG_SEL_MAIN) begin
      main_next = apply_write(reg_wdata, CKG_WMASK_MAIN, 8'h00);
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      main_reg <= CKG_RST_MAIN; // RULE_10
    end else begin
      main_reg <= main_next;
    end
  end

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;

  // Unmapped addresses and idle cycles read as zero
  always_comb begin
    case (rd_sel)
      CKG_SEL_GATE: rdata_next = gate_reg;
      CKG_SEL_PIN: rdata_next = pin_reg;
      CKG_SEL_RUN: rdata_next = run_reg;
      // Bit 5 reads as its stored value ORed with main source bit 4
      CKG_SEL_MAIN: rdata_next = main_reg | {2'h0, main_reg[CKG_MAIN_SRC_BIT], 5'h00};
      default: rdata_next = 8'h00;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // ----------------------------------------
  // Clock pin and system oscillator
  // ----------------------------------------
  ckg_pin_mode_e mode_next;
  logic port_next;
  logic res_next;
  logic ext_next;
  logic port_reg;
  logic res_reg;
  logic ext_reg;

  // Decoded from next values so the pins follow the write that changes them
  always_comb begin
    mode_next = pin_mode(pin_next);
    port_next = (mode_next == CKG_PIN_PORT); // RULE_01
    res_next = (mode_next == CKG_PIN_RESONATOR) && !run_next[CKG_SYS_STOP_BIT]; // RULE_02
    ext_next = (mode_next == CKG_PIN_EXTCLK) && !run_next[CKG_SYS_STOP_BIT]; // RULE_02
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      port_reg <= 1'h1; // RULE_10
      res_reg <= 1'h0; // RULE_10
      ext_reg <= 1'h0;
    end else begin
      port_reg <= port_next;
      res_reg <= res_next;
      ext_reg <= ext_next;
    end
  end

  // ----------------------------------------
  // On-chip oscillator
  // ----------------------------------------
  logic hio_next;
  logic hio_reg;

  always_comb begin
    hio_next = !run_next[CKG_HIO_STOP_BIT]; // RULE_03
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      hio_reg <= 1'h1; // RULE_10
    end else begin
      hio_reg <= hio_next;
    end
  end

  // ----------------------------------------
  // Main system clock source
  // ----------------------------------------
  logic src_next;
  logic src_reg;

  always_comb begin
    src_next = main_next[CKG_MAIN_SRC_BIT]; // RULE_04
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      src_reg <= 1'h0; // RULE_10
    end else begin
      src_reg <= src_next;
    end
  end

  // ----------------------------------------
  // Peripheral gating
  // ----------------------------------------
  wire logic [PERIPH_N-1:0] en_vec;
  wire logic [PERIPH_N-1:0] allow_vec;
  wire logic [PERIPH_N-1:0] hold_vec;
  wire logic [PERIPH_N-1:0] grant_vec;

  // Grant looks at the gate as already stored, so a write in the cycle
  // the gate opens is still refused
  for (genvar i = 0; i < PERIPH_N; i++) begin : g_periph
    logic gate_now;
    logic gate_soon;
    logic en_next;
    logic allow_next;
    logic hold_next;
    logic grant_next;
    logic en_reg;
    logic allow_reg;
    logic hold_reg;
    logic grant_reg;

    always_comb begin
      gate_now = gate_of(gate_reg, i);
      gate_soon = gate_of(gate_next, i);
      en_next = gate_soon; // RULE_05 RULE_06 RULE_07 RULE_08 RULE_09
      allow_next = gate_soon; // RULE_05 RULE_06 RULE_07 RULE_08 RULE_09
      hold_next = !gate_soon; // RULE_05 RULE_06 RULE_07 RULE_08 RULE_09
      grant_next = periph_write_req[i] && gate_now; // RULE_05 RULE_06 RULE_07 RULE_08 RULE_09
    end

    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        en_reg <= 1'h0; // RULE_10
        allow_reg <= 1'h0; // RULE_10
        hold_reg <= 1'h1; // RULE_10
        grant_reg <= 1'h0;
      end else begin
        en_reg <= en_next;
        allow_reg <= allow_next;
        hold_reg <= hold_next;
        grant_reg <= grant_next;
      end
    end

    assign en_vec[i] = en_reg;
    assign allow_vec[i] = allow_reg;
    assign hold_vec[i] = hold_reg;
    assign grant_vec[i] = grant_reg;
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign reg_rdata = rdata_reg;
  assign pin_port_mode = port_reg;
  assign resonator_run = res_reg;
  assign external_clock_accept = ext_reg;
  assign onchip_oscillator_run = hio_reg;
  assign main_source_select = src_reg;
  assign periph_clock_enable = en_vec;
  assign periph_write_allow = allow_vec;
  assign periph_reset_hold = hold_vec;
  assign periph_write_grant = grant_vec;

endmodule

// ==== testbench/ckg_periph_model.sv ====
`timescale 1ns/10ps
module ckg_periph_model (
  // Clock and wanted attempts
  input wire logic clk,
  input wire logic [4:0] attempt,
  // Toward the gate block
  output logic [4:0] periph_write_req
);
  // Attempts launch just after an edge, as a peripheral bus would
  initial periph_write_req = 5'h00;
  always @(posedge clk) periph_write_req <= attempt;
endmodule

// ==== testbench/ckg_properties.sv ====
`timescale 1ns/10ps
module ckg_properties import ckgate_pkg::*; #(
  parameter int PERIPH_N = 5
) (
  // Clock, reset, register port
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [CKG_ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_rdata,
  // Control outputs and peripheral write requests
  input wire logic pin_port_mode,
  input wire logic resonator_run,
  input wire logic external_clock_accept,
  input wire logic onchip_oscillator_run,
  input wire logic main_source_select,
  input wire logic [PERIPH_N-1:0] periph_write_req,
  input wire logic [PERIPH_N-1:0] periph_clock_enable,
  input wire logic [PERIPH_N-1:0] periph_write_allow,
  input wire logic [PERIPH_N-1:0] periph_reset_hold,
  input wire logic [PERIPH_N-1:0] periph_write_grant
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  logic [7:0] wd_q;
  always_ff @(posedge clk) wd_q <= reg_wdata;
  sequence s_wr(a);
    reg_write && reg_addr == a;
  endsequence
  a_gate_write: assert property (s_wr(CKG_ADDR_GATE) |=> periph_clock_enable ==
    {wd_q[0], wd_q[2], wd_q[3], wd_q[5], wd_q[7]}) else $error("gate write");
  a_hold_inverse: assert property (periph_reset_hold == ~periph_clock_enable)
    else $error("reset hold");
  a_allow_clock: assert property (periph_write_allow == periph_clock_enable)
    else $error("write allow");
  a_grant_gate: assert property (periph_write_grant ==
    ($past(periph_write_req) & $past(periph_clock_enable))) else $error("grant");
  a_main_write: assert property (s_wr(CKG_ADDR_MAIN) |=> main_source_select == wd_q[4])
    else $error("main select");
  a_run_write: assert property (s_wr(CKG_ADDR_RUN) |=> onchip_oscillator_run != wd_q[0])
    else $error("onchip run");
  a_pin_write: assert property (s_wr(CKG_ADDR_PIN) |=> pin_port_mode != wd_q[6])
    else $error("pin mode");
  a_port_quiet: assert property (pin_port_mode |-> !resonator_run && !external_clock_accept)
    else $error("port mode drives clock");
  a_read_idle: assert property (!$past(reg_read) |-> reg_rdata == 8'h00) else $error("rdata idle");
endmodule
bind ckgate_top ckg_properties #(.PERIPH_N(PERIPH_N)) u_chk (.*);

// ==== testbench/clock_source_and_peripheral_gating_tb.sv ====
`timescale 1ns/10ps
module clock_source_and_peripheral_gating_tb import ckgate_pkg::*;;
  logic clk = 0, reset_n = 0, reg_write = 0, reg_read = 0;
  logic [19:0] reg_addr = 0;
  logic [7:0] reg_wdata = 0, reg_rdata;
  logic pin_port_mode, resonator_run, external_clock_accept, onchip_oscillator_run;
  logic main_source_select;
  logic [4:0] att = 0, periph_write_req, periph_clock_enable, periph_write_allow;
  logic [4:0] periph_reset_hold, periph_write_grant;
  int errors = 0, checked = 0;
  wire [4:0] st = {pin_port_mode, resonator_run, external_clock_accept,
    onchip_oscillator_run, main_source_select};
  always #4 clk = ~clk;
  ckgate_top u_dut (.*);
  ckg_periph_model u_pm (.clk(clk), .attempt(att), .periph_write_req(periph_write_req));
  task automatic chk(input logic [7:0] s, e);
    checked++;
    if (s !== e) begin
      errors++;
      $display("[FAIL] %0t seen %h want %h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [19:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_write <= 1'h1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_write <= 1'h0;
    #1;
  endtask
  task automatic rd(input logic [19:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_read <= 1'h1;
    reg_addr <= a;
    @(posedge clk);
    reg_read <= 1'h0;
    #1 chk(reg_rdata, e);
  endtask
  task automatic stop_test();
    if (errors == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // ----
  // Tests
  // ----
  initial begin
    repeat (3) @(posedge clk);
    reset_n <= 1'h1;
    #1 chk(st, 8'h12);
    chk(periph_reset_hold, 8'h1F);
    rd(CKG_ADDR_GATE, 8'h00);
    rd(CKG_ADDR_PIN, 8'h00);
    rd(CKG_ADDR_RUN, 8'hC0);
    rd(CKG_ADDR_MAIN, 8'h00);
    rd(20'hF00F1, 8'h00);
    wr(CKG_ADDR_GATE, 8'h21);
    chk(periph_clock_enable, 8'h12);
    chk(periph_reset_hold, 8'h0D);
    wr(CKG_ADDR_GATE, 8'hFF);
    rd(CKG_ADDR_GATE, 8'hAD);
    chk(periph_write_allow, 8'h1F);
    wr(CKG_ADDR_GATE, 8'h00);
    @(posedge clk) att <= 5'h1F;
    repeat (3) @(posedge clk);
    #1 chk(periph_write_grant, 8'h00);
    wr(CKG_ADDR_GATE, 8'h84);
    repeat (2) @(posedge clk);
    #1 chk(periph_write_grant, 8'h09);
    @(posedge clk) att <= 5'h00;
    // Mode bits times stop bit
    for (logic [3:0] m = 0; m < 8; m++) begin
      wr(CKG_ADDR_PIN, {m[1:0], 6'h00});
      wr(CKG_ADDR_RUN, {m[2], 7'h40});
      chk(st, {~m[0], m[1:0] == 2'h1 & ~m[2], m[1:0] == 2'h3 & ~m[2], 2'h2});
    end
    wr(CKG_ADDR_MAIN, 8'h10);
    rd(CKG_ADDR_MAIN, 8'h30);
    chk(main_source_select, 8'h01);
    wr(CKG_ADDR_RUN, 8'h01);
    rd(CKG_ADDR_RUN, 8'h41);
    chk(onchip_oscillator_run, 8'h00);
    // Mid-run reset must restore the power-up state
    @(posedge clk) reset_n <= 1'h0;
    #1 chk(st, 8'h12);
    chk(periph_reset_hold, 8'h1F);
    @(posedge clk) reset_n <= 1'h1;
    rd(CKG_ADDR_RUN, 8'hC0);
    stop_test();
  end
  initial begin
    #20000;
    errors++;
    stop_test();
  end
endmodule
